// >>> design/smve_pkg.sv
// package: register map, field layout, reset values and states of the motion parameter block
package smve_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0]  IDX_VEL_THR    = 8'h60;
   localparam logic [7:0]  IDX_STEP_TIME  = 8'h61;
   localparam logic [7:0]  IDX_LSPT_ZERO  = 8'h62;
   localparam logic [7:0]  IDX_MEAN_CFG   = 8'h63;
   localparam logic [9:0]  ADDR_VEL_THR   = {IDX_VEL_THR, 2'b00};
   localparam logic [9:0]  ADDR_STEP_TIME = {IDX_STEP_TIME, 2'b00};
   localparam logic [9:0]  ADDR_LSPT_ZERO = {IDX_LSPT_ZERO, 2'b00};
   localparam logic [9:0]  ADDR_MEAN_CFG  = {IDX_MEAN_CFG, 2'b00};
   // block-own registers
   localparam logic [9:0]  ADDR_CTRL      = 10'h000;
   localparam logic [9:0]  ADDR_STATE     = 10'h004;
   localparam logic [9:0]  ADDR_INT_STAT  = 10'h008;
   localparam logic [9:0]  ADDR_INT_MASK  = 10'h00c;
   localparam logic [9:0]  ADDR_ENC_MEAN  = 10'h010;
   localparam logic [9:0]  ADDR_EXTRA_VEL = 10'h014;
   // reset values
   localparam logic [23:0] RST_VEL_THR    = 24'h000000;
   localparam logic [31:0] RST_STEP_TIME  = 32'h00000000;
   localparam logic [31:0] RST_LSPT_ZERO  = 32'h00ffffff;
   localparam logic [31:0] RST_MEAN_CFG   = 32'h00000000;
   localparam logic [23:0] RST_EXTRA_VEL  = 24'h000000;
   localparam logic [1:0]  RST_CTRL       = 2'h0;
   localparam logic [2:0]  RST_INT        = 3'h0;
   // field positions
   localparam int ON_LIMIT_LSB   = 0;
   localparam int STALL_THR_LSB  = 8;
   localparam int BLANK_LSB      = 16;
   localparam int GAP_LSB        = 0;
   localparam int FILT_EXP_LSB   = 8;
   localparam int CTRL_CLOSED    = 0;
   localparam int CTRL_LOADSTEP  = 1;
   localparam int EV_STALL       = 0;
   localparam int EV_VARIATION   = 1;
   localparam int EV_STILL       = 2;
   // stall threshold unit is 16 clock cycles
   localparam int STALL_UNIT_SHIFT = 4;
   // variation multiplier is a fraction in 1/256 steps of the resolution
   localparam int VAR_FRAC_SHIFT   = 8;
   // operating modes
   typedef enum logic [2:0] {
      SMVE_OPEN     = 3'b001,
      SMVE_LOADSTEP = 3'b010,
      SMVE_CLOSED   = 3'b100
   } smve_mode_t;
   // blank / first-step measurement states
   typedef enum logic [2:0] {
      SMVE_S_IDLE  = 3'b001,
      SMVE_S_BLANK = 3'b010,
      SMVE_S_MEAS  = 3'b100
   } smve_stall_state_t;
endpackage

// >>> design/smve_stall_if.sv
// interface: settings and results between the main block and its stall timer
`timescale 1ns/1ps
interface smve_stall_if;
   logic [15:0] blank_len;
   logic [7:0]  stall_thr;
   logic [7:0]  on_limit;
   logic        enable;
   logic        fullstep_release;
   logic        step_edge;
   logic        pwm_on;
   logic        compare_en;
   logic        stall;
   logic        pwm_cut;
   modport host (output blank_len, stall_thr, on_limit, enable, fullstep_release,
                 step_edge, pwm_on, input compare_en, stall, pwm_cut);
   modport timer (input blank_len, stall_thr, on_limit, enable, fullstep_release,
                  step_edge, pwm_on, output compare_en, stall, pwm_cut);
endinterface

// >>> design/smve_stall_timer.sv
// module: fullstep blank interval, first-step stall check and pwm on-time cap
`timescale 1ns/1ps
module smve_stall_timer (
   // clock and reset
   input wire logic   hclk,
   input wire logic   hresetn,
   // link to the main block
   smve_stall_if.timer st
);
   smve_pkg::smve_stall_state_t state;
   smve_pkg::smve_stall_state_t next_state;
   logic [15:0] blank_cnt;
   logic [12:0] step_len;
   logic [7:0]  on_cnt;
   logic [12:0] thr_cycles;

   assign thr_cycles = {st.stall_thr, 5'h00} >> 1;

   // state sequencing: blank after each release, then time the first step
   always_comb begin
      next_state = state;
      case (state)
         smve_pkg::SMVE_S_IDLE: begin
            if (st.enable && st.fullstep_release)
               next_state = smve_pkg::SMVE_S_BLANK;
         end
         smve_pkg::SMVE_S_BLANK: begin
            if (!st.enable)
               next_state = smve_pkg::SMVE_S_IDLE;
            else if (blank_cnt >= st.blank_len)
               next_state = smve_pkg::SMVE_S_MEAS;
         end
         smve_pkg::SMVE_S_MEAS: begin
            if (!st.enable || st.step_edge)
               next_state = smve_pkg::SMVE_S_IDLE;
         end
         default: next_state = smve_pkg::SMVE_S_IDLE;
      endcase
      // a new release restarts the blank in any state
      if (st.enable && st.fullstep_release)
         next_state = smve_pkg::SMVE_S_BLANK;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         state <= smve_pkg::SMVE_S_IDLE;
      else
         state <= next_state;
   end

   // blank counter counts cycles since the release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         blank_cnt <= 16'h0000;
      else if (st.fullstep_release)
         blank_cnt <= 16'h0001;
      else if (state == smve_pkg::SMVE_S_BLANK && blank_cnt != 16'hffff)
         blank_cnt <= blank_cnt + 16'h0001;
   end

   // first step length, saturating so a long step never wraps into a false stall
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         step_len <= 13'h0000;
      else if (state != smve_pkg::SMVE_S_MEAS)
         step_len <= 13'h0000;
      else if (step_len != 13'h1fff)
         step_len <= step_len + 13'h0001;
   end

   // stall pulse when the first regular step is shorter than threshold * 16
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         st.stall <= 1'b0;
      else
         st.stall <= (state == smve_pkg::SMVE_S_MEAS) && st.step_edge && st.enable
                     && (step_len < thr_cycles);
   end

   // pwm on-time cap: counts while pwm is on, cut once the limit is met
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         on_cnt <= 8'h00;
      else if (!st.pwm_on)
         on_cnt <= 8'h00;
      else if (on_cnt != 8'hff)
         on_cnt <= on_cnt + 8'h01;
   end

   assign st.pwm_cut    = st.enable && st.pwm_on && (st.on_limit != 8'h00)
                          && (on_cnt >= st.on_limit);
   assign st.compare_en = (state != smve_pkg::SMVE_S_BLANK);
endmodule

// >>> design/smve_top.sv
// module: motion parameter registers with velocity thresholds, timers and encoder mean filter
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Contract
// - open loop: fullstep active while ramp velocity magnitude exceeds fullstep threshold
// - load step mode active only while ramp velocity magnitude exceeds its threshold
// - closed loop: back-EMF compensation starts once encoder velocity reaches threshold
// - load step mode caps pwm on-time during commutation at an 8-bit limit
// - stall threshold bits 15:8 count in units of 16 clock cycles
// - stall event when first regular step after blanking is shorter than threshold
// - after each fullstep release, comparison is blanked for 16-bit cycle count; the code blanks only while load step mode is selected
// - closed loop: extra velocity added to give full-angle compensation velocity
// - load step mode runs a low-speed timer with a 32-bit cycle period
// - without load step mode, mean velocity zeroed after 24-bit still timeout
// - incremental encoder samples spaced by 8-bit gap; software sets it above 32
// - absolute encoders take the sample gap from the serial request period
// - absolute encoders bound reading change by multiplier, capped at resolution
// - multiplier zero uses full encoder resolution as the permitted change
// - mean velocity filter exponent comes from bits 11:8
module smve_top (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // motion inputs
   input  wire logic [31:0] ramp_velocity_now,
   input  wire logic [31:0] encoder_velocity,
   input  wire logic        encoder_change,
   input  wire logic        encoder_absolute,
   input  wire logic [7:0]  serial_request_period,
   input  wire logic [31:0] encoder_input_resolution,
   input  wire logic        serial_valid,
   input  wire logic [31:0] serial_position,
   input  wire logic        fullstep_release,
   input  wire logic        step_edge,
   input  wire logic        pwm_on,
   // mode and timer outputs
   output logic             fullstep_active,
   output logic             load_step_active,
   output logic             backemf_active,
   output logic [24:0]      backemf_full_velocity,
   output logic             compare_enable,
   output logic             pwm_cut,
   output logic             low_speed_tick,
   output logic [31:0]      filtered_encoder_velocity,
   output logic             irq
);
   // software registers
   logic [23:0] velocity_mode_threshold;
   logic [31:0] step_pwm_stall_blank_timing;
   logic [31:0] low_speed_or_zero_vel_timer;
   logic [31:0] encoder_mean_velocity_config;
   logic [23:0] backemf_extra_velocity;
   logic [1:0]  ctrl;
   logic [2:0]  int_status;
   logic [2:0]  int_mask;
   // bus data phase
   logic        wr_pend;
   logic [9:0]  wr_addr;
   logic        acc_phase;
   logic [31:0] next_rdata;
   logic        w1c_en;
   logic [2:0]  w1c_bits;
   // mode and datapath
   smve_pkg::smve_mode_t mode;
   logic [31:0] ramp_mag;
   logic [31:0] enc_mag;
   logic [31:0] lsp_cnt;
   logic [7:0]  gap_cnt;
   logic [7:0]  sample_gap;
   logic        sample_now;
   logic [23:0] still_cnt;
   logic        still_hit;
   logic        still_evt;
   logic signed [32:0] filt_diff;
   logic signed [32:0] filt_step;
   logic        have_prev;
   logic [31:0] prev_pos;
   logic [31:0] pos_delta;
   logic [39:0] var_product;
   logic [31:0] var_scaled;
   logic [31:0] var_bound;
   logic        var_evt;
   logic [7:0]  var_mult;
   logic [3:0]  filt_exp;
   logic [2:0]  events;

   smve_stall_if st ();

   smve_stall_timer u_stall (
      .hclk    (hclk),
      .hresetn (hresetn),
      .st      (st)
   );

   // ---------------- bus slave ----------------
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign acc_phase = hsel && hready && htrans[1];

   // writes land in the data phase, so the address is held one cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 10'h000;
      end else begin
         wr_pend <= acc_phase && hwrite;
         wr_addr <= haddr[9:0];
      end
   end

   // the parameter registers are write-only; they read back as zero
   always_comb begin
      next_rdata = 32'h00000000;
      if (haddr[31:10] == 22'h000000) begin
         case ({haddr[9:2], 2'b00})
            smve_pkg::ADDR_CTRL:      next_rdata = {30'h00000000, ctrl};
            smve_pkg::ADDR_STATE:     next_rdata = {26'h0000000, pwm_cut, compare_enable,
                                                    backemf_active, load_step_active,
                                                    fullstep_active, still_hit};
            smve_pkg::ADDR_INT_STAT:  next_rdata = {29'h00000000, int_status};
            smve_pkg::ADDR_INT_MASK:  next_rdata = {29'h00000000, int_mask};
            smve_pkg::ADDR_ENC_MEAN:  next_rdata = filtered_encoder_velocity;
            default:                  next_rdata = 32'h00000000;
         endcase
      end
   end

   // read data is registered at the address phase and stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (acc_phase && !hwrite)
         hrdata <= next_rdata;
   end

   // parameter and control register writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         velocity_mode_threshold      <= smve_pkg::RST_VEL_THR;
         step_pwm_stall_blank_timing  <= smve_pkg::RST_STEP_TIME;
         low_speed_or_zero_vel_timer  <= smve_pkg::RST_LSPT_ZERO;
         encoder_mean_velocity_config <= smve_pkg::RST_MEAN_CFG;
         backemf_extra_velocity       <= smve_pkg::RST_EXTRA_VEL;
         ctrl                         <= smve_pkg::RST_CTRL;
         int_mask                     <= smve_pkg::RST_INT;
      end else if (wr_pend) begin
         case (wr_addr)
            smve_pkg::ADDR_VEL_THR:    velocity_mode_threshold      <= hwdata[23:0];
            smve_pkg::ADDR_STEP_TIME:  step_pwm_stall_blank_timing  <= hwdata;
            smve_pkg::ADDR_LSPT_ZERO:  low_speed_or_zero_vel_timer  <= hwdata;
            smve_pkg::ADDR_MEAN_CFG:   encoder_mean_velocity_config <= hwdata;
            smve_pkg::ADDR_EXTRA_VEL:  backemf_extra_velocity       <= hwdata[23:0];
            smve_pkg::ADDR_CTRL:       ctrl                         <= hwdata[1:0];
            smve_pkg::ADDR_INT_MASK:   int_mask                     <= hwdata[2:0];
            default: ;
         endcase
      end
   end

   // ---------------- interrupts ----------------
   assign w1c_en   = wr_pend && (wr_addr == smve_pkg::ADDR_INT_STAT);
   assign w1c_bits = w1c_en ? hwdata[2:0] : 3'h0;
   assign events   = {still_evt, var_evt, st.stall};

   // set beats clear so an event in the clearing cycle is kept
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         int_status <= smve_pkg::RST_INT;
      else
         int_status <= (int_status & ~w1c_bits) | events;
   end

   assign irq = |(int_status & int_mask);

   // ---------------- mode selection ----------------
   // closed loop takes precedence: the shared 0x60 field then means back-EMF start
   always_comb begin
      if (ctrl[smve_pkg::CTRL_CLOSED])
         mode = smve_pkg::SMVE_CLOSED;
      else if (ctrl[smve_pkg::CTRL_LOADSTEP])
         mode = smve_pkg::SMVE_LOADSTEP;
      else
         mode = smve_pkg::SMVE_OPEN;
   end

   assign ramp_mag = ramp_velocity_now[31] ? (~ramp_velocity_now + 32'h00000001)
                                           : ramp_velocity_now;
   assign enc_mag  = encoder_velocity[31] ? (~encoder_velocity + 32'h00000001)
                                          : encoder_velocity;

   // threshold comparisons, registered so the mode flags are glitch free
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fullstep_active  <= 1'b0;
         load_step_active <= 1'b0;
         backemf_active   <= 1'b0;
      end else begin
         fullstep_active  <= (mode == smve_pkg::SMVE_OPEN)
                             && (ramp_mag > {8'h00, velocity_mode_threshold});
         load_step_active <= (mode == smve_pkg::SMVE_LOADSTEP)
                             && (ramp_mag > {8'h00, velocity_mode_threshold});
         backemf_active   <= (mode == smve_pkg::SMVE_CLOSED)
                             && (enc_mag >= {8'h00, velocity_mode_threshold});
      end
   end

   // velocity at which compensation reaches its full angle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         backemf_full_velocity <= 25'h0000000;
      else
         backemf_full_velocity <= {1'b0, velocity_mode_threshold}
                                  + {1'b0, backemf_extra_velocity};
   end

   // ---------------- stall timer hookup ----------------
   assign st.on_limit  = step_pwm_stall_blank_timing[smve_pkg::ON_LIMIT_LSB +: 8];
   assign st.stall_thr = step_pwm_stall_blank_timing[smve_pkg::STALL_THR_LSB +: 8];
   assign st.blank_len = step_pwm_stall_blank_timing[smve_pkg::BLANK_LSB +: 16];
   assign st.enable    = (mode == smve_pkg::SMVE_LOADSTEP);
   assign st.fullstep_release = fullstep_release;
   assign st.step_edge = step_edge;
   assign st.pwm_on    = pwm_on && load_step_active;
   assign compare_enable = st.compare_en;
   assign pwm_cut        = st.pwm_cut;

   // ---------------- low-speed timer ----------------
   // period 0 stops the timer rather than ticking every cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lsp_cnt        <= 32'h00000000;
         low_speed_tick <= 1'b0;
      end else if (mode != smve_pkg::SMVE_LOADSTEP
                   || low_speed_or_zero_vel_timer == 32'h00000000) begin
         lsp_cnt        <= 32'h00000000;
         low_speed_tick <= 1'b0;
      end else if (lsp_cnt >= low_speed_or_zero_vel_timer - 32'h00000001) begin
         lsp_cnt        <= 32'h00000000;
         low_speed_tick <= 1'b1;
      end else begin
         lsp_cnt        <= lsp_cnt + 32'h00000001;
         low_speed_tick <= 1'b0;
      end
   end

   // ---------------- encoder mean velocity ----------------
   assign filt_exp   = encoder_mean_velocity_config[smve_pkg::FILT_EXP_LSB +: 4];
   assign var_mult   = encoder_mean_velocity_config[smve_pkg::GAP_LSB +: 8];
   // absolute encoders ignore the programmed gap
   assign sample_gap = encoder_absolute ? serial_request_period
                       : encoder_mean_velocity_config[smve_pkg::GAP_LSB +: 8];
   assign sample_now = (gap_cnt >= sample_gap);

   // sample spacing counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         gap_cnt <= 8'h00;
      else if (sample_now)
         gap_cnt <= 8'h00;
      else
         gap_cnt <= gap_cnt + 8'h01;
   end

   // still timeout counts cycles since the last incremental change
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         still_cnt <= 24'h000000;
      else if (encoder_change || mode == smve_pkg::SMVE_LOADSTEP)
         still_cnt <= 24'h000000;
      else if (!still_hit)
         still_cnt <= still_cnt + 24'h000001;
   end

   assign still_hit = (mode != smve_pkg::SMVE_LOADSTEP) && !encoder_change
                      && (still_cnt >= low_speed_or_zero_vel_timer[23:0]);
   assign still_evt = still_hit && (still_cnt == low_speed_or_zero_vel_timer[23:0]);

   assign filt_diff = $signed({encoder_velocity[31], encoder_velocity})
                    - $signed({filtered_encoder_velocity[31], filtered_encoder_velocity});
   assign filt_step = filt_diff >>> filt_exp;

   // exponential average, held at zero while the encoder stands still
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         filtered_encoder_velocity <= 32'h00000000;
      else if (still_hit)
         filtered_encoder_velocity <= 32'h00000000;
      else if (sample_now)
         filtered_encoder_velocity <= filtered_encoder_velocity
                                      + filt_step[31:0];
   end

   // ---------------- serial reading variation ----------------
   assign var_product = encoder_input_resolution * var_mult;
   assign var_scaled  = var_product[smve_pkg::VAR_FRAC_SHIFT +: 32];
   assign var_bound   = (var_mult == 8'h00) ? encoder_input_resolution
                        : (var_scaled > encoder_input_resolution) ? encoder_input_resolution
                        : var_scaled;
   assign pos_delta   = (serial_position >= prev_pos) ? (serial_position - prev_pos)
                                                      : (prev_pos - serial_position);

   // compare each reading with the one before; first reading only primes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         have_prev <= 1'b0;
         prev_pos  <= 32'h00000000;
         var_evt   <= 1'b0;
      end else begin
         var_evt <= encoder_absolute && serial_valid && have_prev
                    && (pos_delta > var_bound);
         if (!encoder_absolute) begin
            have_prev <= 1'b0;
         end else if (serial_valid) begin
            have_prev <= 1'b1;
            prev_pos  <= serial_position;
         end
      end
   end
endmodule

// >>> sim/smve_drv_model.sv
// partner model: driver side making fullstep release, pwm on phase and regular steps
`timescale 1ns/1ps
module smve_drv_model (
   // clock
   input wire logic       hclk,
   // command from the bench
   input wire logic       go,
   input wire logic [7:0] gap,
   // driver feedback
   output logic           fullstep_release,
   output logic           step_edge,
   output logic           pwm_on
);
   logic       run = 1'b0;
   logic [7:0] cnt = 8'h0;
   // one release per command, then the first regular step gap + 1 cycles later
   always_ff @(posedge hclk) begin
      fullstep_release <= go & ~run;
      step_edge        <= run & (cnt == gap);
      cnt              <= run ? cnt + 8'h1 : 8'h0;
      if (go)
         run <= 1'b1;
      else if (cnt == gap)
         run <= 1'b0;
   end
   // pwm stays on through the whole step, so a long step meets the on-time cap
   assign pwm_on = run;
endmodule

// >>> sim/smve_props.sv
// checker: port-level properties of the motion parameter block
`timescale 1ns/1ps
module smve_props (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus answer
   input wire logic        hreadyout,
   input wire logic        hresp,
   // motion signals
   input wire logic [31:0] ramp_velocity_now,
   input wire logic        fullstep_release,
   input wire logic        pwm_on,
   input wire logic        fullstep_active,
   input wire logic        load_step_active,
   input wire logic        backemf_active,
   input wire logic        compare_enable,
   input wire logic        pwm_cut
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // zero wait states, so a stalled bus means a broken slave
   chk_ready_always: assert property (hreadyout) else $error("hreadyout low");
   chk_resp_okay: assert property (!hresp) else $error("error response seen");
   // a zero ramp can never exceed any threshold
   chk_fullstep_speed: assert property (fullstep_active |-> $past(ramp_velocity_now) != 32'h0)
      else $error("fullstep active at zero ramp");
   chk_loadstep_speed: assert property (load_step_active |-> $past(ramp_velocity_now) != 32'h0)
      else $error("load step active at zero ramp");
   chk_mode_excl: assert property (!(fullstep_active && load_step_active))
      else $error("open loop and load step both active");
   chk_emf_excl: assert property (!(fullstep_active && backemf_active))
      else $error("open loop and closed loop both active");
   chk_blank_start: assert property (fullstep_release && load_step_active |=> !compare_enable)
      else $error("comparison not blanked after release");
   chk_cut_pwm: assert property (pwm_cut |-> pwm_on && !$rose(pwm_on))
      else $error("pwm cut outside a running on phase");
endmodule
bind smve_top smve_props u_props (.hclk, .hresetn, .hreadyout, .hresp, .ramp_velocity_now,
   .fullstep_release, .pwm_on, .fullstep_active, .load_step_active, .backemf_active,
   .compare_enable, .pwm_cut);

// >>> sim/smve_top_tb.sv
// testbench: register, threshold, stall, timer and mean filter scenarios
`timescale 1ns/1ps
module smve_top_tb;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, filtered_encoder_velocity;
   logic [31:0] ramp_velocity_now = 32'h0, encoder_velocity = 32'h0, serial_position = 32'h0;
   logic [31:0] encoder_input_resolution = 32'h100;
   logic [7:0]  serial_request_period = 8'h40, gap = 8'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        encoder_change = 1'b0, encoder_absolute = 1'b0, serial_valid = 1'b0;
   logic        hreadyout, hresp, fullstep_release, step_edge, pwm_on, fullstep_active;
   logic        load_step_active, backemf_active, compare_enable, pwm_cut, low_speed_tick, irq;
   logic [24:0] backemf_full_velocity;
   wire         hready = hreadyout;
   int          miscompares = 0, cmp_count = 0, n;
   smve_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout, .hrdata, .hresp, .ramp_velocity_now, .encoder_velocity, .encoder_change,
      .encoder_absolute, .serial_request_period, .encoder_input_resolution, .serial_valid,
      .serial_position, .fullstep_release, .step_edge, .pwm_on, .fullstep_active,
      .load_step_active, .backemf_active, .backemf_full_velocity, .compare_enable, .pwm_cut,
      .low_speed_tick, .filtered_encoder_velocity, .irq);
   smve_drv_model drv (.hclk, .go, .gap, .fullstep_release, .step_edge, .pwm_on);
   // free-running 100 MHz clock
   initial forever #5 hclk = ~hclk;
   task automatic summarize;
      $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, s, e);
      end
   endtask
   // next edge with hready high; a stuck bus ends the run
   task automatic edge_ready;
      @(posedge hclk);
      for (n = 0; hready !== 1'b1; n++) begin
         if (n > 20) begin
            miscompares++;
            summarize();
         end
         @(posedge hclk);
      end
   endtask
   // one single word transfer; read data lands in q
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d = 32'h0);
      hsel   <= 1'b1;
      haddr  <= {22'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      edge_ready();
      htrans <= 2'h0;
      hwdata <= d;
      edge_ready();
      q = hrdata;
   endtask
   // fixed wait of k clock edges, with no condition sampled
   task automatic settle(input int k);
      repeat (k) @(posedge hclk);
   endtask
   task automatic t_regs;
      bus(0, smve_pkg::ADDR_CTRL);
      chk(q, 32'h0);
      bus(0, smve_pkg::ADDR_VEL_THR);
      chk(q, 32'h0); // write-only place reads zero
      bus(1, 10'h3fc, 32'hffffffff);
      bus(0, 10'h3fc);
      chk(q, 32'h0);
      bus(0, smve_pkg::ADDR_CTRL);
      chk(q, 32'h0);
   endtask
   task automatic t_thresholds;
      bus(1, smve_pkg::ADDR_VEL_THR, 32'd100);
      ramp_velocity_now <= 32'd101;
      settle(3);
      chk(fullstep_active, 1);
      ramp_velocity_now <= 32'd100;
      settle(3);
      chk(fullstep_active, 0);
      ramp_velocity_now <= -32'd101;
      settle(3);
      chk(fullstep_active, 1);
      bus(1, smve_pkg::ADDR_CTRL, 32'h2);
      settle(3);
      chk({fullstep_active, load_step_active}, 2'b01);
      bus(1, smve_pkg::ADDR_CTRL, 32'h1);
      bus(1, smve_pkg::ADDR_EXTRA_VEL, 32'd5);
      encoder_velocity <= 32'd100;
      settle(3);
      chk(backemf_active, 1);
      chk(backemf_full_velocity, 25'd105);
      encoder_velocity <= 32'd99;
      settle(3);
      chk(backemf_active, 0);
   endtask
   // fullstep release, blank of 4, threshold 1 unit of 16 cycles, on-time cap of 3
   task automatic t_stall(input logic [7:0] g, input logic [31:0] e);
      gap <= g;
      go  <= 1'b1;
      @(posedge hclk);
      go  <= 1'b0;
      settle(2);
      chk(compare_enable, 0);
      settle(4);
      chk(pwm_cut, 1);
      settle(80);
      bus(0, smve_pkg::ADDR_INT_STAT);
      chk(q, e);
      chk(irq, e[0]);
      bus(1, smve_pkg::ADDR_INT_STAT, 32'h1);
      settle(1);
      chk(irq, 0);
   endtask
   task automatic t_filter;
      bus(1, smve_pkg::ADDR_CTRL, 32'h0);
      encoder_velocity <= 32'd1000;
      encoder_change   <= 1'b1;
      bus(1, smve_pkg::ADDR_MEAN_CFG, 32'h00000028);
      encoder_change   <= 1'b0;
      for (n = 0; n < 200 && filtered_encoder_velocity !== 32'd1000; n++) @(posedge hclk);
      chk(filtered_encoder_velocity, 32'd1000);
      bus(1, smve_pkg::ADDR_MEAN_CFG, 32'h00000428);
      encoder_velocity <= 32'd2000;
      for (n = 0; n < 200 && filtered_encoder_velocity === 32'd1000; n++) @(posedge hclk);
      chk(filtered_encoder_velocity, 32'd1062);
   endtask
   task automatic t_timers;
      bus(1, smve_pkg::ADDR_CTRL, 32'h2);
      bus(1, smve_pkg::ADDR_LSPT_ZERO, 32'd10);
      for (n = 0; n < 40 && low_speed_tick !== 1'b1; n++) @(posedge hclk);
      for (n = 0; n == 0 || (n < 40 && low_speed_tick !== 1'b1); n++) @(posedge hclk);
      chk(n, 10);
      bus(1, smve_pkg::ADDR_CTRL, 32'h0);
      for (n = 0; n < 100 && filtered_encoder_velocity !== 32'h0; n++) @(posedge hclk);
      chk(filtered_encoder_velocity, 32'h0);
      bus(0, smve_pkg::ADDR_INT_STAT);
      chk(q, 32'h4);
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_thresholds();
      bus(1, smve_pkg::ADDR_CTRL, 32'h2);
      ramp_velocity_now <= 32'd101;
      bus(1, smve_pkg::ADDR_STEP_TIME, 32'h00040103);
      bus(1, smve_pkg::ADDR_INT_MASK, 32'h1);
      t_stall(8'd10, 32'h1);
      t_stall(8'd60, 32'h0);
      t_filter();
      t_timers();
      summarize();
   end
endmodule
